// File: logic/clock_gating_pkg.sv
// Package with register map, field layout and shared helpers for the unit clock gating block.
package clock_gating_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] RUN_ENABLES_OFS = 12'h108;
  localparam logic [ADDR_W-1:0] SLEEP_ENABLES_OFS = 12'h118;
  localparam logic [ADDR_W-1:0] DEEP_ENABLES_OFS = 12'h128;
  localparam logic [ADDR_W-1:0] RUN_CLOCK_CONFIG_OFS = 12'h060;
  localparam logic [ADDR_W-1:0] INT_STATUS_OFS = 12'h200;
  localparam logic [ADDR_W-1:0] INT_MASK_OFS = 12'h204;

  // ----------------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------------
  localparam int NUM_UNITS = 9;
  localparam int NUM_PORTS = 7;
  localparam int PHY_BIT = 30;
  localparam int MAC_BIT = 28;
  localparam int PORT_G_BIT = 6;
  localparam int UNIT_MAC = 7;
  localparam int UNIT_PHY = 8;
  localparam logic [31:0] ENABLES_RW_MASK = 32'h5000007F;
  localparam logic [31:0] ENABLES_RESET = 32'h00000000;
  localparam int AUTO_GATING_BIT = 0;
  localparam int STAT_FAULT_BIT = 0;
  localparam int STAT_SLEEP_BIT = 1;
  localparam int NUM_EVENTS = 2;

  typedef enum logic [1:0] {
    MODE_RUN,
    MODE_SLEEP,
    MODE_DEEP
  } power_mode_t;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Register word to one enable per unit: ports A..G, then MAC, then PHY.
  function automatic logic [NUM_UNITS-1:0] toUnits(input logic [31:0] word);
    return {word[PHY_BIT], word[MAC_BIT], word[PORT_G_BIT:0]};
  endfunction : toUnits

  function automatic logic [31:0] fromUnits(input logic [NUM_UNITS-1:0] units);
    logic [31:0] word;
    word = ENABLES_RESET;
    word[PORT_G_BIT:0] = units[NUM_PORTS-1:0];
    word[MAC_BIT] = units[UNIT_MAC];
    word[PHY_BIT] = units[UNIT_PHY];
    return word;
  endfunction : fromUnits

  // Byte-lane merge of an APB write into an old register value.
  function automatic logic [31:0] strobeMerge(input logic [31:0] old, input logic [31:0] wdata,
                                              input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = wdata[i*8 +: 8];
      end
    end
    return res;
  endfunction : strobeMerge

endpackage : clock_gating_pkg

// File: logic/enable_select.sv
// Chooses which enable set drives the unit clocks for the present power mode.
`timescale 1ns/100ps
`default_nettype none
module enable_select (
  input wire clock_gating_pkg::power_mode_t mode,
  input wire logic autoGating,
  input wire logic [clock_gating_pkg::NUM_UNITS-1:0] runUnits,
  input wire logic [clock_gating_pkg::NUM_UNITS-1:0] sleepUnits,
  input wire logic [clock_gating_pkg::NUM_UNITS-1:0] deepUnits,
  output logic [clock_gating_pkg::NUM_UNITS-1:0] effUnits
);

  // Without automatic gating the run set keeps applying in both sleep modes.
  always_comb begin
    effUnits = runUnits;
    case (mode)
      clock_gating_pkg::MODE_SLEEP: begin
        if (autoGating) begin
          effUnits = sleepUnits;
        end
      end
      clock_gating_pkg::MODE_DEEP: begin
        if (autoGating) begin
          effUnits = deepUnits;
        end
      end
      default: begin
        effUnits = runUnits;
      end
    endcase
  end

endmodule : enable_select
`default_nettype wire

// File: logic/unit_access_guard.sv
// Flags accesses to units whose clock is stopped, answering them with a registered fault.
`timescale 1ns/100ps
`default_nettype none
module unit_access_guard (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic periphAccess,
  input wire logic [3:0] periphUnit,
  input wire logic [clock_gating_pkg::NUM_UNITS-1:0] unitEnables,
  output logic periphFault
);

  typedef struct packed {
    logic fault;
  } guard_state_t;

  guard_state_t state_q;
  guard_state_t state_d;

  // An index past the last unit is treated as unclocked, so it faults too.
  always_comb begin
    state_d = state_q;
    state_d.fault = 1'b0;
    if (periphAccess) begin
      if (periphUnit >= 4'(clock_gating_pkg::NUM_UNITS)) begin
        state_d.fault = 1'b1;
      end else begin
        state_d.fault = ~unitEnables[periphUnit];
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign periphFault = state_q.fault;

endmodule : unit_access_guard
`default_nettype wire

// File: logic/sleep_mode_clock_gating.sv
// Unit clock gating control with run, sleep and deep-sleep enable registers behind APB.
//
// Register access over APB was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module sleep_mode_clock_gating (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [clock_gating_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sleepReq,
  input wire logic deepSleepReq,
  input wire logic periphAccess,
  input wire logic [3:0] periphUnit,
  output logic periphFault,
  output logic [clock_gating_pkg::NUM_UNITS-1:0] unitClockEnable,
  output logic irq
);

  localparam int NU = clock_gating_pkg::NUM_UNITS;
  localparam int NE = clock_gating_pkg::NUM_EVENTS;

  typedef struct packed {
    logic [NU-1:0] runUnits;
    logic [NU-1:0] sleepUnits;
    logic [NU-1:0] deepUnits;
    logic autoGating;
    clock_gating_pkg::power_mode_t mode;
    logic [NE-1:0] intStatus;
    logic [NE-1:0] intMask;
    logic [31:0] rdata;
    logic ready;
    logic slvErr;
    logic [NU-1:0] unitEn;
    logic irq;
  } gating_state_t;

  gating_state_t state_q;
  gating_state_t state_d;
  logic [NU-1:0] effUnits;
  logic faultPulse;

  // ----------------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------------
  enable_select u_select (
    .mode(state_q.mode),
    .autoGating(state_q.autoGating),
    .runUnits(state_q.runUnits),
    .sleepUnits(state_q.sleepUnits),
    .deepUnits(state_q.deepUnits),
    .effUnits(effUnits)
  );

  unit_access_guard u_guard (
    .clock(clock),
    .rst_n(rst_n),
    .periphAccess(periphAccess),
    .periphUnit(periphUnit),
    .unitEnables(state_q.unitEn),
    .periphFault(faultPulse)
  );

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  logic accessWait;
  logic accessDone;
  logic [NE-1:0] events;
  logic [31:0] rdWord;
  logic rdErr;
  logic [31:0] wrWord;

  assign accessWait = psel & penable & ~state_q.ready;
  assign accessDone = psel & penable & state_q.ready;

  always_comb begin
    state_d = state_q;
    rdWord = 32'h00000000;
    rdErr = 1'b0;
    wrWord = 32'h00000000;
    events = '0;

    // Deep sleep takes priority when both requests are raised.
    if (deepSleepReq) begin
      state_d.mode = clock_gating_pkg::MODE_DEEP;
    end else if (sleepReq) begin
      state_d.mode = clock_gating_pkg::MODE_SLEEP;
    end else begin
      state_d.mode = clock_gating_pkg::MODE_RUN;
    end

    // Stopping a clock is a plain enable drop; the glitch-free gate cell sits at each unit.
    state_d.unitEn = effUnits;

    events[clock_gating_pkg::STAT_FAULT_BIT] = faultPulse;
    events[clock_gating_pkg::STAT_SLEEP_BIT] = (state_d.mode == clock_gating_pkg::MODE_SLEEP) &&
                                               (state_q.mode != clock_gating_pkg::MODE_SLEEP);

    // Read decode; unused and reserved bits come back as zero.
    if (paddr == clock_gating_pkg::RUN_ENABLES_OFS) begin
      rdWord = clock_gating_pkg::fromUnits(state_q.runUnits);
    end else if (paddr == clock_gating_pkg::SLEEP_ENABLES_OFS) begin
      rdWord = clock_gating_pkg::fromUnits(state_q.sleepUnits);
    end else if (paddr == clock_gating_pkg::DEEP_ENABLES_OFS) begin
      rdWord = clock_gating_pkg::fromUnits(state_q.deepUnits);
    end else if (paddr == clock_gating_pkg::RUN_CLOCK_CONFIG_OFS) begin
      rdWord[clock_gating_pkg::AUTO_GATING_BIT] = state_q.autoGating;
    end else if (paddr == clock_gating_pkg::INT_STATUS_OFS) begin
      rdWord[NE-1:0] = state_q.intStatus;
    end else if (paddr == clock_gating_pkg::INT_MASK_OFS) begin
      rdWord[NE-1:0] = state_q.intMask;
    end else begin
      rdErr = 1'b1;
    end

    // Response is prepared in the first access cycle and presented in the second.
    if (accessWait) begin
      state_d.ready = 1'b1;
      state_d.slvErr = rdErr;
      state_d.rdata = pwrite ? 32'h00000000 : rdWord;
    end else if (accessDone) begin
      state_d.ready = 1'b0;
      state_d.slvErr = 1'b0;
      state_d.rdata = 32'h00000000;
    end

    // Writes land only at the completing edge; the event sets below still win over a clear.
    if (accessDone && pwrite) begin
      if (paddr == clock_gating_pkg::RUN_ENABLES_OFS) begin
        wrWord = clock_gating_pkg::strobeMerge(clock_gating_pkg::fromUnits(state_q.runUnits), pwdata, pstrb);
        state_d.runUnits = clock_gating_pkg::toUnits(wrWord);
      end else if (paddr == clock_gating_pkg::SLEEP_ENABLES_OFS) begin
        wrWord = clock_gating_pkg::strobeMerge(clock_gating_pkg::fromUnits(state_q.sleepUnits), pwdata, pstrb);
        state_d.sleepUnits = clock_gating_pkg::toUnits(wrWord);
      end else if (paddr == clock_gating_pkg::DEEP_ENABLES_OFS) begin
        wrWord = clock_gating_pkg::strobeMerge(clock_gating_pkg::fromUnits(state_q.deepUnits), pwdata, pstrb);
        state_d.deepUnits = clock_gating_pkg::toUnits(wrWord);
      end else if (paddr == clock_gating_pkg::RUN_CLOCK_CONFIG_OFS) begin
        if (pstrb[0]) begin
          state_d.autoGating = pwdata[clock_gating_pkg::AUTO_GATING_BIT];
        end
      end else if (paddr == clock_gating_pkg::INT_STATUS_OFS) begin
        if (pstrb[0]) begin
          state_d.intStatus = state_q.intStatus & ~pwdata[NE-1:0];
        end
      end else if (paddr == clock_gating_pkg::INT_MASK_OFS) begin
        if (pstrb[0]) begin
          state_d.intMask = pwdata[NE-1:0];
        end
      end
    end

    state_d.intStatus = state_d.intStatus | events;
    state_d.irq = |(state_d.intStatus & state_d.intMask);
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign prdata = state_q.rdata;
  assign pready = state_q.ready;
  assign pslverr = state_q.slvErr;
  assign periphFault = faultPulse;
  assign unitClockEnable = state_q.unitEn;
  assign irq = state_q.irq;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  // Marks the first cycle after reset, so that the reset values can be checked there.
  logic seenCycle_q;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      seenCycle_q <= 1'b0;
    end else begin
      seenCycle_q <= 1'b1;
    end
  end

  a_reset_all_off:
    assert property (!seenCycle_q |-> (state_q.sleepUnits == '0) && (unitClockEnable == '0))
    else $error("Enables not zero after reset.");

  a_sleep_applies:
    assert property ((state_q.mode == clock_gating_pkg::MODE_SLEEP) && state_q.autoGating
                     |=> unitClockEnable == $past(state_q.sleepUnits))
    else $error("Sleep enables not applied in sleep with automatic gating.");

  a_run_in_sleep:
    assert property ((state_q.mode == clock_gating_pkg::MODE_SLEEP) && !state_q.autoGating
                     |=> unitClockEnable == $past(state_q.runUnits))
    else $error("Run enables not kept in sleep without automatic gating.");

  a_run_mode_set:
    assert property ((state_q.mode == clock_gating_pkg::MODE_RUN)
                     |=> unitClockEnable == $past(state_q.runUnits))
    else $error("Run enables not applied in run mode.");

  a_stopped_unit_off:
    assert property (((state_q.mode == clock_gating_pkg::MODE_SLEEP) && state_q.autoGating &&
                      !state_q.sleepUnits[clock_gating_pkg::UNIT_PHY])
                     |=> !unitClockEnable[clock_gating_pkg::UNIT_PHY])
    else $error("Stopped unit still clocked.");

  // Back-to-back accesses are legal, so the pulse width is checked by the no-access case instead.
  a_gated_fault:
    assert property (periphAccess && (periphUnit < 4'(NU)) && !unitClockEnable[periphUnit]
                     |=> periphFault)
    else $error("Access to stopped unit did not fault.");

  a_clocked_no_fault:
    assert property (periphAccess && (periphUnit < 4'(NU)) && unitClockEnable[periphUnit] |=> !periphFault)
    else $error("Access to clocked unit faulted.");

  a_reserved_read_zero:
    assert property (pready && !pslverr && (prdata & ~clock_gating_pkg::ENABLES_RW_MASK) != 32'h00000000
                     |-> $past(paddr) != clock_gating_pkg::SLEEP_ENABLES_OFS)
    else $error("Reserved bits of sleep enables read non-zero.");

  a_sleep_write:
    assert property (accessDone && pwrite && (paddr == clock_gating_pkg::SLEEP_ENABLES_OFS) && (pstrb == 4'hF)
                     |=> state_q.sleepUnits == clock_gating_pkg::toUnits($past(pwdata)))
    else $error("Sleep enables write not stored on its bits.");

  a_apb_one_wait:
    assert property (accessWait |=> pready ##1 !pready)
    else $error("APB answer not given after exactly one wait cycle.");

  a_fault_irq:
    assert property (periphFault && state_q.intMask[clock_gating_pkg::STAT_FAULT_BIT] |=> irq)
    else $error("Unmasked fault did not raise the interrupt.");

  a_fault_one_cycle:
    assert property (!periphAccess |=> !periphFault)
    else $error("Fault answer raised without an access.");

  a_deep_applies:
    assert property ((state_q.mode == clock_gating_pkg::MODE_DEEP) && state_q.autoGating
                     |=> unitClockEnable == $past(state_q.deepUnits))
    else $error("Deep-sleep enables not applied in deep sleep with automatic gating.");

  a_run_in_deep:
    assert property ((state_q.mode == clock_gating_pkg::MODE_DEEP) && !state_q.autoGating
                     |=> unitClockEnable == $past(state_q.runUnits))
    else $error("Run enables not kept in deep sleep without automatic gating.");

  a_deep_wins:
    assert property (deepSleepReq |=> state_q.mode == clock_gating_pkg::MODE_DEEP)
    else $error("Deep-sleep request did not win over the sleep request.");

  a_sleep_entry_flag:
    assert property ((state_q.mode != clock_gating_pkg::MODE_SLEEP) && sleepReq && !deepSleepReq
                     |=> state_q.intStatus[clock_gating_pkg::STAT_SLEEP_BIT])
    else $error("Sleep entry did not set its status bit.");

  a_fault_sets_status:
    assert property (periphFault |=> state_q.intStatus[clock_gating_pkg::STAT_FAULT_BIT])
    else $error("Fault did not set its status bit.");

  // A fault in the same cycle wins over the clear, so that case is left out here.
  a_status_clear:
    assert property (accessDone && pwrite && (paddr == clock_gating_pkg::INT_STATUS_OFS) && pstrb[0] &&
                     pwdata[clock_gating_pkg::STAT_FAULT_BIT] && !periphFault
                     |=> !state_q.intStatus[clock_gating_pkg::STAT_FAULT_BIT])
    else $error("Writing one did not clear the fault status bit.");

  a_config_write:
    assert property (accessDone && pwrite && (paddr == clock_gating_pkg::RUN_CLOCK_CONFIG_OFS) && pstrb[0]
                     |=> state_q.autoGating == $past(pwdata[clock_gating_pkg::AUTO_GATING_BIT]))
    else $error("Automatic gating select not stored.");

  a_mask_write:
    assert property (accessDone && pwrite && (paddr == clock_gating_pkg::INT_MASK_OFS) && pstrb[0]
                     |=> state_q.intMask == $past(pwdata[NE-1:0]))
    else $error("Interrupt mask not stored.");

  a_irq_masked:
    assert property ((state_q.intMask == '0) && !(accessDone && pwrite) |=> !irq)
    else $error("Interrupt raised while every event was masked.");

  a_ready_one_cycle:
    assert property (pready |=> !pready)
    else $error("Ready stood for more than one cycle.");

  a_idle_bus_quiet:
    assert property (!pready |-> (prdata == 32'h00000000) && !pslverr)
    else $error("Read data or error shown without ready.");

  a_write_no_data:
    assert property (accessWait && pwrite |=> prdata == 32'h00000000)
    else $error("Write answer carried read data.");

  a_mapped_no_error:
    assert property (accessWait && (paddr == clock_gating_pkg::SLEEP_ENABLES_OFS) |=> pready && !pslverr)
    else $error("Sleep enables access answered with an error.");

  // ----------------------------------------------------------------------
  // Cover properties
  // ----------------------------------------------------------------------
  c_sleep_auto: cover property ((state_q.mode == clock_gating_pkg::MODE_SLEEP) && state_q.autoGating);
  c_deep_auto: cover property ((state_q.mode == clock_gating_pkg::MODE_DEEP) && state_q.autoGating);
  c_fault_seen: cover property (periphFault);
  c_sleep_written: cover property (accessDone && pwrite && (paddr == clock_gating_pkg::SLEEP_ENABLES_OFS));
  c_irq_raised: cover property (irq);

endmodule : sleep_mode_clock_gating
`default_nettype wire

// File: dv/apb_software_host.sv
// Software-side APB master model that drives register transfers into the gating block.
`timescale 1ns/100ps
`default_nettype none
module apb_software_host (
  input wire logic clock,
  input wire logic pready,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [clock_gating_pkg::ADDR_W-1:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb,
  output logic timedOut
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = 32'h0;
    pstrb = 4'hF;
    timedOut = 1'b0;
  end

  // Whole words unless the caller passes a narrower pstrb; reserved bits are written exactly as the caller gives them.
  task automatic xfer(input logic wr, input logic [clock_gating_pkg::ADDR_W-1:0] addr, input logic [31:0] data,
                      input logic [3:0] strb = 4'hF);
    int n;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= data;
    pstrb <= strb;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      timedOut <= 1'b1;
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
endmodule : apb_software_host
`default_nettype wire

// File: dv/sleep_mode_clock_gating_tb.sv
// Self-checking testbench for the unit clock gating block.
`timescale 1ns/100ps
`default_nettype none
module sleep_mode_clock_gating_tb;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, periphFault, irq, timedOut;
  logic sleepReq = 1'b0;
  logic deepSleepReq = 1'b0;
  logic periphAccess = 1'b0;
  logic [3:0] periphUnit = 4'h0;
  logic [clock_gating_pkg::ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rnd, runW, sleepW;
  logic [3:0] pstrb;
  logic [clock_gating_pkg::NUM_UNITS-1:0] unitClockEnable;
  logic [32:0] busNotes[$];
  logic [32:0] note;
  logic [32:0] expUnits;
  logic faultNotes[$];
  logic accPrev = 1'b0;
  int num_errors = 0;
  int comparisons = 0;

  always #2.5 clock = ~clock;

  apb_software_host host (.clock(clock), .pready(pready), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .timedOut(timedOut));

  sleep_mode_clock_gating dut (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sleepReq(sleepReq), .deepSleepReq(deepSleepReq), .periphAccess(periphAccess), .periphUnit(periphUnit),
    .periphFault(periphFault), .unitClockEnable(unitClockEnable), .irq(irq));

  // ----------------------------------------------------------------------
  // Checking
  // ----------------------------------------------------------------------
  task automatic chk(input string what, input logic [32:0] exp, input logic [32:0] got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : results

  always @(posedge timedOut) begin
    num_errors++;
    results();
  end

  // Write answers carry no data, so only the error flag is compared for them.
  always @(posedge clock) begin
    if (psel && penable && pready === 1'b1) begin
      note = busNotes.pop_front();
      chk("apb answer", note, {pslverr, pwrite ? note[31:0] : prdata});
    end
    if (accPrev) begin
      chk("unit fault", {32'h0, faultNotes.pop_front()}, {32'h0, periphFault});
    end else if (rst_n && periphFault !== 1'b0) begin
      chk("unexpected fault", 33'h0, {32'h0, periphFault});
    end
    accPrev <= periphAccess;
  end

  // ----------------------------------------------------------------------
  // Stimulus helpers
  // ----------------------------------------------------------------------
  function automatic logic [32:0] units(input logic [31:0] w);
    return {24'h0, w[30], w[28], w[6:0]};
  endfunction : units

  task automatic regOp(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [32:0] exp,
                       input logic [3:0] s = 4'hF);
    busNotes.push_back(exp);
    host.xfer(wr, a, d, s);
  endtask : regOp

  task automatic access(input int u, input logic exp);
    @(posedge clock);
    faultNotes.push_back(exp);
    periphAccess <= 1'b1;
    periphUnit <= u[3:0];
    @(posedge clock);
    periphAccess <= 1'b0;
    @(posedge clock);
  endtask : access

  // The enables follow a mode change two cycles later; one spare cycle avoids edge races.
  task automatic settle();
    repeat (3) @(posedge clock);
    @(negedge clock);
  endtask : settle

  initial begin
    void'($urandom(32'h3812));
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    regOp(1'b0, clock_gating_pkg::SLEEP_ENABLES_OFS, 32'h0, 33'h0);
    regOp(1'b0, clock_gating_pkg::RUN_ENABLES_OFS, 32'h0, 33'h0);
    settle();
    chk("enables after reset", 33'h0, {24'h0, unitClockEnable});
    $display("test reset done");

    access(3, 1'b1);
    access(9, 1'b1);
    settle();
    chk("irq masked", 33'h0, {32'h0, irq});
    regOp(1'b0, clock_gating_pkg::INT_STATUS_OFS, 32'h0, 33'h1);
    regOp(1'b1, clock_gating_pkg::INT_MASK_OFS, 32'h1, 33'h0);
    settle();
    chk("irq raised", 33'h1, {32'h0, irq});
    regOp(1'b1, clock_gating_pkg::INT_STATUS_OFS, 32'h1, 33'h0);
    settle();
    chk("irq cleared", 33'h0, {32'h0, irq});
    $display("test fault interrupt done");

    regOp(1'b1, clock_gating_pkg::SLEEP_ENABLES_OFS, 32'hFFFFFFFF, 33'h0);
    regOp(1'b0, clock_gating_pkg::SLEEP_ENABLES_OFS, 32'h0, 33'h05000007F);
    rnd = $urandom();
    regOp(1'b1, clock_gating_pkg::SLEEP_ENABLES_OFS, rnd, 33'h0);
    regOp(1'b0, clock_gating_pkg::SLEEP_ENABLES_OFS, 32'h0, {1'b0, rnd & 32'h5000007F});
    regOp(1'b1, clock_gating_pkg::SLEEP_ENABLES_OFS, 32'hFFFFFFFF, 33'h0, 4'h8);
    regOp(1'b0, clock_gating_pkg::SLEEP_ENABLES_OFS, 32'h0, {1'b0, (rnd & 32'h0000007F) | 32'h50000000});
    regOp(1'b0, 12'h300, 32'h0, 33'h100000000);
    regOp(1'b1, 12'h304, 32'hFFFFFFFF, 33'h100000000);
    $display("test register layout done");

    runW = 32'h00000015;
    sleepW = (rnd & 32'h5000007F) | 32'h10000042;
    regOp(1'b1, clock_gating_pkg::RUN_ENABLES_OFS, runW, 33'h0);
    regOp(1'b1, clock_gating_pkg::SLEEP_ENABLES_OFS, sleepW, 33'h0);
    @(posedge clock);
    sleepReq <= 1'b1;
    settle();
    chk("sleep without auto gating", units(runW), {24'h0, unitClockEnable});
    regOp(1'b1, clock_gating_pkg::RUN_CLOCK_CONFIG_OFS, 32'h1, 33'h0);
    settle();
    chk("sleep with auto gating", units(sleepW), {24'h0, unitClockEnable});
    expUnits = units(sleepW);
    for (int i = 0; i < 9; i++) begin
      access(i, ~expUnits[i]);
    end
    @(posedge clock);
    deepSleepReq <= 1'b1;
    settle();
    chk("deep sleep enables", 33'h0, {24'h0, unitClockEnable});
    @(posedge clock);
    deepSleepReq <= 1'b0;
    sleepReq <= 1'b0;
    settle();
    chk("run enables", units(runW), {24'h0, unitClockEnable});
    $display("test power modes done");
    repeat (4) @(posedge clock);
    rst_n <= 1'b0;
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    regOp(1'b0, clock_gating_pkg::SLEEP_ENABLES_OFS, 32'h0, 33'h0);
    settle();
    chk("enables after second reset", 33'h0, {24'h0, unitClockEnable});
    $display("test second reset done");
    results();
  end
endmodule : sleep_mode_clock_gating_tb
`default_nettype wire
